// *** core/watchdog_sleep_wakeup.sv ***
// Watchdog timer with sleep entry and wake-up arbitration
`timescale 1ns/1ps
`default_nettype none
`include "wdt_sleep_regs.svh"

// Operation
// - Watchdog counts RC ticks, independent of the stopped main clock.
// - Time-out while running issues a watchdog device reset.
// - Time-out while sleeping wakes the device, no reset.
// - Every time-out clears the active-low timeout flag.
// - Cleared enable fuse (config bit 2) disables the watchdog until the bit is written back to one.
// - Shared divider; assign bit selects owner, three rate bits set postscale.
// - Clear and sleep instructions reset counter and owned postscaler.
// - Clear instruction zeroes divider, assignment bit kept.
// - Sleep entry clears power-down flag, sets timeout flag, stops oscillator.
// - I/O drive states are held while asleep.
// - Master clear in sleep resets; time-out or enabled interrupts resume.
// - Power-down flag set at power-up, cleared only by executed sleep.
// - Only individually enabled sources wake, regardless of global enable.
// - After wake run next instruction, then vector if global enable set.
// - Sleep prefetches the next address as first post-wake instruction.
// - Pending enabled interrupt turns sleep into a no-operation.
// - Interrupt during sleep: finish sleep effects, then wake at once.
// - Only clockless peripherals may raise wake interrupts during sleep.
module watchdog_sleep_wakeup
   import wdt_sleep_pkg::*;
(
   input  wire logic        clk_sys,        // System clock, 200 MHz
   input  wire logic        arst_n,         // Async reset, active low
   input  wire logic        clkEn,          // Freezes all state when low
   input  wire logic        psel,           // APB select
   input  wire logic        penable,        // APB enable
   input  wire logic        pwrite,         // APB direction
   input  wire logic [15:0] paddr,          // APB byte address
   input  wire logic [31:0] pwdata,         // APB write data
   output logic             pready,         // APB ready
   output logic [31:0]      prdata,         // APB read data
   output logic             pslverr,        // APB error, unmapped address
   input  wire cpu_cmd_t    cpuCmd,         // Clear and sleep instruction pulses
   input  wire wake_src_t   wakeFlag,       // Interrupt flags of wake sources
   input  wire wake_src_t   wakeEnable,     // Individual enables
   input  wire logic        periphClockless,// Peripheral source runs without clock
   input  wire logic        global_irq_enable, // Global interrupt enable
   input  wire logic        master_clear_n, // External reset input, synchronous
   input  wire logic [7:0]  ioDriveIn,      // Live pin drive levels
   input  wire logic [7:0]  ioEnIn,         // Live pin output enables
   output logic             wdtReset,       // Watchdog device reset pulse
   output logic             deviceReset,    // Master clear reset pulse
   output logic             oscEnable,      // Main oscillator driver on
   output logic             sleeping,       // In power-down mode
   output logic             resumeNext,     // Execute prefetched instruction pulse
   output logic             vectorIrq,      // Branch to interrupt vector pulse
   output logic             timeout_flag_n, // Status bit 4
   output logic             powerdown_flag_n, // Status bit 3
   output logic [7:0]       ioDriveOut,     // Pin levels, held in sleep
   output logic [7:0]       ioEnOut,        // Pin enables, held in sleep
   output logic             irq             // Level interrupt
);

   // ==========================================================
   // Constants
   localparam int RC_CYC = (`RC_TICK_NS + `CLK_NS - 1) / `CLK_NS;
   localparam int EV_W = 3;

   function automatic logic [7:0] ratio(input logic [2:0] r);
      ratio = 8'h01 << r;
   endfunction

   // ==========================================================
   // State
   logic [7:0]  opt_q;
   logic [7:0]  cfg_q;
   logic [EV_W-1:0] evt_q;
   logic [EV_W-1:0] mask_q;
   logic [15:0] rcDiv_q;
   logic [15:0] wdtCnt_q;
   logic [7:0]  post_q;
   logic        to_q, pd_q;
   pwr_t        pwr_q;
   logic        pending_q;
   logic        vecPend_q;

   // Status flag pins come straight from their flip-flops
   assign timeout_flag_n   = to_q;
   assign powerdown_flag_n = pd_q;

   // ==========================================================
   // APB decode
   wire access   = psel & penable;
   wire wrAcc    = access & pwrite & clkEn;
   wire hitOpt   = paddr == `OPT_ADDR;
   wire hitCfg   = paddr == `CFG_ADDR;
   wire hitStat  = paddr == `STAT_ADDR;
   wire hitEvt   = paddr == `EVT_ADDR;
   wire hitMask  = paddr == `MASK_ADDR;
   wire hitWake  = paddr == `WAKE_ADDR;
   wire hitCmd   = paddr == `CMD_ADDR;
   wire mapped   = hitOpt | hitCfg | hitStat | hitEvt | hitMask | hitWake | hitCmd;
   wire wrOpt    = wrAcc & hitOpt;
   wire wrCfg    = wrAcc & hitCfg;
   wire wrEvt    = wrAcc & hitEvt;
   wire wrMask   = wrAcc & hitMask;
   wire swClear  = wrAcc & hitCmd & pwdata[0];

   wire [7:0] statVal = {3'h0, to_q, pd_q, 3'h0};
   wire [31:0] rdMux  = hitOpt  ? {24'h0, opt_q}
                      : hitCfg  ? {24'h0, cfg_q}
                      : hitStat ? {24'h0, statVal}
                      : hitEvt  ? {29'h0, evt_q}
                      : hitMask ? {29'h0, mask_q}
                      : hitWake ? {29'h0, wakeEnable}
                      : 32'h0;

   // ==========================================================
   // Watchdog and divider
   wire wdtOn      = cfg_q[`CFG_WATCHDOG_ENABLE_FUSE_BIT];
   wire toWdt      = opt_q[`OPT_ASSIGN_BIT];
   wire [7:0] postRatio = toWdt ? ratio(opt_q[2:0]) : 8'h01;
   wire rcTick     = rcDiv_q == 16'(RC_CYC - 1);
   wire baseWrap   = rcTick & (wdtCnt_q == `WDT_BASE_COUNT - 16'h1);
   wire timeout    = wdtOn & baseWrap & (post_q == postRatio - 8'h01);
   wire clrInstr   = cpuCmd.clearInstr | swClear;
   wire wakeReqRaw = |(wakeFlag & wakeEnable);
   wire [2:0] sleepGate = {2'b11, periphClockless};
   wire wakeReq    = |(wakeFlag & wakeEnable & (pwr_q == ST_SLEEP ? sleepGate : 3'b111));
   wire sleepNop   = cpuCmd.sleepInstr & (pwr_q == ST_RUN) & wakeReqRaw;
   wire sleepDo    = cpuCmd.sleepInstr & (pwr_q == ST_RUN) & ~wakeReqRaw;
   wire wdtClr     = clrInstr | sleepDo;
   wire mclrSleep  = ~master_clear_n & (pwr_q == ST_SLEEP);
   wire [EV_W-1:0] evtSet = {sleepDo, timeout & (pwr_q == ST_SLEEP), timeout & (pwr_q == ST_RUN)};

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rcDiv_q  <= 16'h0;
         wdtCnt_q <= 16'h0;
         post_q   <= 8'h0;
      end
      else if (clkEn)
      begin
         rcDiv_q <= rcTick ? 16'h0 : rcDiv_q + 16'h1;
         if (wdtClr || !wdtOn || timeout)
         begin
            wdtCnt_q <= 16'h0;
            post_q   <= 8'h0;
         end
         else if (rcTick)
         begin
            wdtCnt_q <= baseWrap ? 16'h0 : wdtCnt_q + 16'h1;
            if (baseWrap)
               post_q <= post_q + 8'h01;
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         opt_q  <= `OPT_RST;
         cfg_q  <= `CFG_RST;
         evt_q  <= '0;
         mask_q <= '0;
      end
      else if (clkEn)
      begin
         if (wrOpt)
            opt_q <= pwdata[7:0];
         if (wrCfg)
            cfg_q <= pwdata[7:0];
         // Set beats a same-cycle write-one clear
         evt_q <= (evt_q & ~(wrEvt ? pwdata[EV_W-1:0] : '0)) | evtSet;
         if (wrMask)
            mask_q <= pwdata[EV_W-1:0];
      end
   end

   // ==========================================================
   // Power state and status flags
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pwr_q     <= ST_RUN;
         to_q      <= 1'b1;
         pd_q      <= 1'b1;
         pending_q <= 1'b0;
         vecPend_q <= 1'b0;
      end
      else if (clkEn)
      begin
         pending_q  <= 1'b0;
         vecPend_q  <= 1'b0;
         if (timeout)
            to_q <= 1'b0;
         else if (sleepDo || clrInstr)
            to_q <= 1'b1;
         if (sleepDo)
            pd_q <= 1'b0;
         else if (clrInstr)
            pd_q <= 1'b1;
         case (pwr_q)
            ST_RUN:
               if (sleepDo)
                  pwr_q <= ST_SLEEP;
            ST_SLEEP:
               if (mclrSleep)
                  pwr_q <= ST_RUN;
               else if (timeout || wakeReq)
               begin
                  pwr_q     <= ST_RUN;
                  pending_q <= 1'b1;
                  vecPend_q <= wakeReq & global_irq_enable;
               end
            default:
               pwr_q <= ST_RUN;
         endcase
      end
   end

   // ==========================================================
   // Registered outputs
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pready      <= 1'b0;
         prdata      <= 32'h0;
         pslverr     <= 1'b0;
         wdtReset    <= 1'b0;
         deviceReset <= 1'b0;
         oscEnable   <= 1'b1;
         sleeping    <= 1'b0;
         resumeNext  <= 1'b0;
         vectorIrq   <= 1'b0;
         ioDriveOut  <= 8'h0;
         ioEnOut     <= 8'h0;
         irq         <= 1'b0;
      end
      else if (clkEn)
      begin
         pready      <= psel & ~penable;
         prdata      <= (psel & ~penable & ~pwrite) ? rdMux : 32'h0;
         pslverr     <= psel & ~penable & ~mapped;
         wdtReset    <= timeout & (pwr_q == ST_RUN);
         deviceReset <= mclrSleep;
         oscEnable   <= (pwr_q == ST_SLEEP) ? (mclrSleep | timeout | wakeReq) : ~sleepDo;
         sleeping    <= (pwr_q == ST_SLEEP) ? ~(mclrSleep | timeout | wakeReq) : sleepDo;
         resumeNext  <= pending_q;
         vectorIrq   <= pending_q & vecPend_q;
         if (pwr_q == ST_RUN && !sleepDo)
         begin
            ioDriveOut <= ioDriveIn;
            ioEnOut    <= ioEnIn;
         end
         irq <= |(evt_q & mask_q);
      end
   end

   // ==========================================================
   // Checks
   AST_NOP_SLEEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && sleepNop |=> pd_q == $past(pd_q) && pwr_q == ST_RUN)
      else $error("sleep with pending interrupt changed state");
   AST_SLEEP_FLAGS: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && sleepDo && !timeout |=> !pd_q && to_q && pwr_q == ST_SLEEP)
      else $error("sleep entry flags wrong");
   AST_TO_CLEAR: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && timeout |=> !to_q)
      else $error("timeout flag not cleared");
   AST_RUN_RESET: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && timeout && pwr_q == ST_RUN |=> wdtReset)
      else $error("no watchdog reset");
   AST_SLEEP_WAKE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && timeout && pwr_q == ST_SLEEP && master_clear_n |=> pwr_q == ST_RUN && !wdtReset)
      else $error("sleep time-out did not wake");
   AST_FUSE_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && !cfg_q[`CFG_WATCHDOG_ENABLE_FUSE_BIT] |=> wdtCnt_q == 16'h0 && !wdtReset)
      else $error("disabled watchdog counted");
   AST_CLR_CNT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && wdtClr |=> wdtCnt_q == 16'h0 && post_q == 8'h0)
      else $error("clear did not reset counter");
   AST_ASSIGN_KEEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && clrInstr && !wrOpt |=> opt_q == $past(opt_q))
      else $error("clear altered divider assignment");
   AST_VECTOR: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && pending_q && !vecPend_q |=> !vectorIrq)
      else $error("vector without global enable");
   AST_IO_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && pwr_q == ST_SLEEP |=> ioDriveOut == $past(ioDriveOut))
      else $error("pins changed in sleep");

   // ==========================================================
   // Checks on bus, events, wake and freeze
   AST_PREADY_NEXT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && psel && !penable
      |=> pready)
      else $error("setup not answered");
   AST_ERR_UNMAPPED: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && psel && !penable && !mapped
      |=> pready && pslverr)
      else $error("unmapped access without error");
   AST_RD_OPT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && psel && !penable && !pwrite && hitOpt
      |=> prdata == {24'h0, $past(opt_q)})
      else $error("options read data wrong");
   AST_WR_OPT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && wrOpt
      |=> {24'h0, opt_q} == ($past(pwdata) & 32'h000000ff))
      else $error("options write lost");
   AST_EVT_SET: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && evtSet != 3'h0
      |=> (evt_q & $past(evtSet)) == $past(evtSet))
      else $error("event not recorded");
   AST_EVT_KEEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && !wrEvt
      |=> (evt_q & $past(evt_q)) == $past(evt_q))
      else $error("event lost without clear");
   AST_IRQ_ON: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && (evt_q & mask_q) != 3'h0
      |=> irq)
      else $error("unmasked event without interrupt");
   AST_IRQ_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && (evt_q & mask_q) == 3'h0
      |=> !irq)
      else $error("interrupt without unmasked event");
   AST_MASTER_CLEAR_N_WAKE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && mclrSleep
      |=> deviceReset && pwr_q == ST_RUN && !pending_q)
      else $error("master clear in sleep did not reset");
   AST_IRQ_WAKE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && pwr_q == ST_SLEEP && master_clear_n && wakeReq
      |=> pwr_q == ST_RUN && pending_q)
      else $error("enabled source did not wake");
   AST_STAY_ASLEEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && pwr_q == ST_SLEEP && master_clear_n && !timeout && (wakeFlag & wakeEnable & sleepGate) == 3'h0
      |=> pwr_q == ST_SLEEP)
      else $error("woke without a clockless source");
   AST_RESUME: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && pending_q
      |=> resumeNext)
      else $error("no resume after wake");
   AST_VECTOR_ON: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && pending_q && vecPend_q
      |=> vectorIrq)
      else $error("no vector with global enable");
   AST_OSC_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && sleepDo
      |=> !oscEnable && sleeping)
      else $error("oscillator left on in sleep");
   AST_OSC_BACK: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && pwr_q == ST_SLEEP && (timeout || wakeReq)
      |=> oscEnable && !sleeping)
      else $error("oscillator not restarted on wake");
   AST_PD_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && pd_q && !sleepDo
      |=> pd_q)
      else $error("power-down flag cleared without sleep");
   AST_TO_SET: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && !timeout && (sleepDo || clrInstr)
      |=> to_q)
      else $error("timeout flag not set");
   AST_EN_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
      clkEn && pwr_q == ST_SLEEP
      |=> ioEnOut == $past(ioEnOut))
      else $error("pin enables changed in sleep");
   AST_FREEZE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !clkEn
      |=> pwr_q == $past(pwr_q) && wdtCnt_q == $past(wdtCnt_q) && evt_q == $past(evt_q))
      else $error("state moved while disabled");

endmodule
`default_nettype wire

// *** core/wdt_sleep_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef WDT_SLEEP_REGS_SVH
`define WDT_SLEEP_REGS_SVH
`define OPT_IDX          16'h0081
`define CFG_IDX          16'h2007
`define OPT_ADDR         16'h0204
`define CFG_ADDR         16'h801c
`define STAT_ADDR        16'h0010
`define EVT_ADDR         16'h0014
`define MASK_ADDR        16'h0018
`define WAKE_ADDR        16'h001c
`define CMD_ADDR         16'h0020
`define OPT_RST          8'hff
`define CFG_RST          8'hff
`define CFG_WATCHDOG_ENABLE_FUSE_BIT     2
`define OPT_ASSIGN_BIT   3
`define STAT_PD_BIT      3
`define STAT_TO_BIT      4
`define RC_TICK_NS       18000
`define CLK_NS           5
`define WDT_BASE_COUNT   16'h0004
`endif

// *** core/wdt_sleep_pkg.sv ***
// Types shared by the watchdog and sleep control block
package wdt_sleep_pkg;
   typedef enum logic [1:0] {ST_RUN, ST_SLEEP} pwr_t;
   typedef struct packed {
      logic       clearInstr;
      logic       sleepInstr;
   } cpu_cmd_t;
   typedef struct packed {
      logic       extInt;
      logic       portChange;
      logic       periph;
   } wake_src_t;
endpackage

// *** tb/cpu_core_model.sv ***
// Behavioural processor core: issues clear and sleep instruction pulses, counts wake and reset pulses
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model
   import wdt_sleep_pkg::*;
(
   input  wire logic     clk_sys,     // System clock
   input  wire logic     resumeNext,  // Prefetched instruction runs
   input  wire logic     vectorIrq,   // Branch to interrupt vector
   input  wire logic     deviceReset, // Master clear reset pulse
   input  wire logic     wdtReset,    // Watchdog reset pulse
   output var  cpu_cmd_t cmd          // Instruction pulses
);
   int resumes = 0;
   int vectors = 0;
   int mclrResets = 0;
   int dogResets = 0;

   initial cmd = '0;

   // =============================================
   // Pulse counters
   // Sampled in the active region, so each count sees the pulse that stood last cycle
   always @(posedge clk_sys)
   begin
      if (resumeNext === 1'b1) resumes++;
      if (vectorIrq === 1'b1) vectors++;
      if (deviceReset === 1'b1) mclrResets++;
      if (wdtReset === 1'b1) dogResets++;
   end

   // =============================================
   // Instruction issue, one cycle wide
   task automatic issue(input logic isSleep);
   begin
      @(posedge clk_sys);
      cmd.sleepInstr <= isSleep;
      cmd.clearInstr <= ~isSleep;
      @(posedge clk_sys);
      cmd <= '0;
   end
   endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Testbench for the watchdog, sleep and wake-up block
`timescale 1ns/1ps
`default_nettype none
`include "wdt_sleep_regs.svh"
module tb_top
   import wdt_sleep_pkg::*;
;
   logic clk_sys, arst_n, clkEn, psel, penable, pwrite, pready, pslverr;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rdData;
   logic rdErr, periphClockless, global_irq_enable, master_clear_n, toFlagN, pdFlagN;
   logic wdtReset, deviceReset, oscEnable, sleeping, resumeNext, vectorIrq, irq;
   logic [7:0] ioDriveIn, ioEnIn, ioDriveOut, ioEnOut;
   cpu_cmd_t cpuCmd;
   wake_src_t wakeFlag, wakeEnable;
   int mismatches = 0;
   int compares = 0;

   watchdog_sleep_wakeup dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .cpuCmd(cpuCmd), .wakeFlag(wakeFlag), .wakeEnable(wakeEnable),
      .periphClockless(periphClockless), .global_irq_enable(global_irq_enable),
      .master_clear_n(master_clear_n), .ioDriveIn(ioDriveIn), .ioEnIn(ioEnIn), .wdtReset(wdtReset),
      .deviceReset(deviceReset), .oscEnable(oscEnable), .sleeping(sleeping), .resumeNext(resumeNext),
      .vectorIrq(vectorIrq), .timeout_flag_n(toFlagN), .powerdown_flag_n(pdFlagN), .ioDriveOut(ioDriveOut),
      .ioEnOut(ioEnOut), .irq(irq));

   cpu_core_model cpu_u (.clk_sys(clk_sys), .resumeNext(resumeNext), .vectorIrq(vectorIrq),
      .deviceReset(deviceReset), .wdtReset(wdtReset), .cmd(cpuCmd));

   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // =============================================
   // Shared tasks
   task automatic conclude();
   begin
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
   begin
      compares++;
      if (got !== exp)
      begin
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
         mismatches++;
      end
   end
   endtask

   // Request held until pready is sampled high; no latency assumed
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
      int n;
   begin
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk(8'h00, 8'h01, "no pready");
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      apb(1'b1, a, {24'h0, v});
   endtask

   task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input string what);
   begin
      apb(1'b0, a, 32'h0);
      chk(rdData[7:0], exp, what);
   end
   endtask

   task automatic waitSleep(input logic lvl);
      int n;
   begin
      n = 0;
      while (sleeping !== lvl && n < 20000) begin @(posedge clk_sys); n++; end
      chk({7'h0, sleeping}, {7'h0, lvl}, "sleep state");
   end
   endtask

   function automatic logic [7:0] stat(input logic tmo, input logic pwr);
      return (8'(tmo) << `STAT_TO_BIT) | (8'(pwr) << `STAT_PD_BIT);
   endfunction

   // =============================================
   // Watchdog on the run itself, about 80000 cycles
   initial
   begin
      #400000;
      $display("mismatch at %0t: run took too long", $time);
      mismatches++;
      conclude();
   end

   // =============================================
   // Main sequence
   initial
   begin
      arst_n = 1'b0; clkEn = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
      wakeFlag = '0; wakeEnable = '0; periphClockless = 1'b0; global_irq_enable = 1'b0;
      master_clear_n = 1'b1; ioDriveIn = 8'h00; ioEnIn = 8'h00;
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      rdchk(`OPT_ADDR, `OPT_RST, "options reset");
      rdchk(`CFG_ADDR, `CFG_RST, "config reset");
      rdchk(`STAT_ADDR, stat(1'b1, 1'b1), "status at power-up");
      chk({7'h0, oscEnable}, 8'h01, "oscillator on");
      apb(1'b0, 16'h0100, 32'h0);
      chk({7'h0, rdErr}, 8'h01, "unmapped error");
      wr(`OPT_ADDR, 8'h05);
      rdchk(`OPT_ADDR, 8'h05, "options readback");
      wakeEnable <= 3'b101;
      rdchk(`WAKE_ADDR, 8'h05, "wake enables");
      ioDriveIn <= 8'ha5; ioEnIn <= 8'h3c;
      cpu_u.issue(1'b1);
      waitSleep(1'b1);
      ioDriveIn <= 8'h5a; ioEnIn <= 8'hc3;
      repeat (4) @(posedge clk_sys);
      chk(ioDriveOut, 8'ha5, "drive held");
      chk(ioEnOut, 8'h3c, "enable held");
      chk({7'h0, oscEnable}, 8'h00, "oscillator off");
      rdchk(`STAT_ADDR, stat(1'b1, 1'b0), "status in sleep");
      rdchk(`EVT_ADDR, 8'h04, "sleep event");
      chk({7'h0, irq}, 8'h00, "irq masked");
      wr(`MASK_ADDR, 8'h04);
      repeat (2) @(posedge clk_sys);
      chk({7'h0, irq}, 8'h01, "irq raised");
      wr(`EVT_ADDR, 8'h04);
      repeat (2) @(posedge clk_sys);
      chk({7'h0, irq}, 8'h00, "irq cleared");
      wakeFlag <= 3'b010;
      repeat (20) @(posedge clk_sys);
      chk({7'h0, sleeping}, 8'h01, "disabled source ignored");
      wakeFlag <= 3'b110;
      waitSleep(1'b0);
      repeat (4) @(posedge clk_sys);
      chk(8'(cpu_u.resumes), 8'h01, "resume after wake");
      chk(8'(cpu_u.vectors), 8'h00, "no vector, global off");
      rdchk(`STAT_ADDR, stat(1'b1, 1'b0), "status after wake");
      wakeFlag <= 3'b000; wakeEnable <= 3'b001; global_irq_enable <= 1'b1;
      cpu_u.issue(1'b1);
      waitSleep(1'b1);
      wakeFlag <= 3'b001;
      repeat (20) @(posedge clk_sys);
      chk({7'h0, sleeping}, 8'h01, "clocked peripheral silent");
      periphClockless <= 1'b1;
      waitSleep(1'b0);
      repeat (4) @(posedge clk_sys);
      chk(8'(cpu_u.vectors), 8'h01, "vector, global on");
      wakeFlag <= 3'b000; global_irq_enable <= 1'b0;
      cpu_u.issue(1'b0);
      rdchk(`STAT_ADDR, stat(1'b1, 1'b1), "flags after clear");
      wakeEnable <= 3'b100; wakeFlag <= 3'b100;
      cpu_u.issue(1'b1);
      repeat (20) @(posedge clk_sys);
      chk({7'h0, sleeping}, 8'h00, "pending irq, sleep is nop");
      rdchk(`STAT_ADDR, stat(1'b1, 1'b1), "flags kept by nop");
      wakeFlag <= 3'b000;
      cpu_u.issue(1'b1);
      waitSleep(1'b1);
      clkEn <= 1'b0;
      wakeFlag <= 3'b100;
      repeat (8) @(posedge clk_sys);
      chk({7'h0, sleeping}, 8'h01, "frozen while disabled");
      wakeFlag <= 3'b000;
      clkEn <= 1'b1;
      master_clear_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      master_clear_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk(8'(cpu_u.mclrResets), 8'h01, "master clear resets");
      chk(8'(cpu_u.dogResets), 8'h00, "no watchdog reset");
      cpu_u.issue(1'b1);
      waitSleep(1'b1);
      waitSleep(1'b0);
      repeat (4) @(posedge clk_sys);
      chk(8'(cpu_u.resumes), 8'h03, "resume after time-out wake");
      chk(8'(cpu_u.dogResets), 8'h00, "time-out in sleep wakes only");
      chk({7'h0, oscEnable}, 8'h01, "oscillator back on");
      chk({6'h0, toFlagN, pdFlagN}, 8'h00, "flag pins after time-out");
      rdchk(`EVT_ADDR, 8'h06, "sleep time-out event");
      repeat (`WDT_BASE_COUNT * (`RC_TICK_NS / `CLK_NS) + 600) @(posedge clk_sys);
      chk(8'(cpu_u.dogResets), 8'h01, "run time-out resets");
      rdchk(`STAT_ADDR, stat(1'b0, 1'b0), "status after run time-out");
      rdchk(`EVT_ADDR, 8'h07, "run time-out event");
      wr(`CFG_ADDR, 8'hfb);
      repeat (`WDT_BASE_COUNT * (`RC_TICK_NS / `CLK_NS) + 600) @(posedge clk_sys);
      chk(8'(cpu_u.dogResets), 8'h01, "fuse off, no time-out");
      conclude();
   end
endmodule
`default_nettype wire
